// ---- verilog/scan_pkg.sv ----
// Purpose: Shared constants and carriers for the boundary-scan test port.
// Assumes: Test clock is sampled by ref_clk (10 MHz); test clock far slower.
// Notes: Instruction codes and identity value are local choices.
// Function
// - The controller is a sixteen-state sequencer following the standard state diagram.
// - The loaded instruction picks which of three data registers sits between serial in and out.
// - A one-bit bypass register gives a single-stage path.
// - A 256-cell boundary register can be captured, shifted and updated.
// - A 32-bit identification register can be captured and shifted out.
// - The boundary cells form one continuous shift chain across the pins.
// - Test logic runs apart from the system logic and its state.
// - Output cells drive and input cells capture pins for interconnect tests.
// - Sampling captures live pins and shifts them out without disturbing them.
// - The bypass instruction shrinks the path to one stage.
// - One instruction puts all pin drivers into a non-driving state.
// - One instruction holds outputs at preloaded boundary levels.
package scan_pkg;

  localparam int BSR_LEN  = 256;
  localparam int IDR_LEN  = 32;
  localparam int IR_LEN   = 4;
  localparam int PIN_CNT  = 128;   // Each pin owns an input and an output cell

  localparam logic [IR_LEN-1:0] INS_EXTEST = 4'h0;
  localparam logic [IR_LEN-1:0] INS_IDCODE = 4'h1;
  localparam logic [IR_LEN-1:0] INS_SAMPLE = 4'h2;
  localparam logic [IR_LEN-1:0] INS_HIGHZ  = 4'h9;
  localparam logic [IR_LEN-1:0] INS_CLAMP  = 4'hc;
  localparam logic [IR_LEN-1:0] INS_BYPASS = 4'hf;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1; // Fixed pattern, low bits 01

  // Arbitrary identity value, not tied to any real part
  localparam logic [IDR_LEN-1:0] ID_VALUE  = 32'h1234_5677;

  localparam logic [2:0] SYNC_RST = 3'h0;

  typedef enum {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_t;

  // Pin sampled inputs from the test port
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst;
  } port_in_t;

  // Pin-side view of one group of device pins
  typedef struct packed {
    logic [PIN_CNT-1:0] core_out;
    logic [PIN_CNT-1:0] core_oe;
    logic [PIN_CNT-1:0] pad_in;
  } pin_side_t;

endpackage

// ---- verilog/edge_sync.sv ----
// Purpose: Two-stage synchroniser for the test port pins with edge finding.
// Assumes: Pins are asynchronous to ref_clk.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module edge_sync
  import scan_pkg::*;
(
  input  wire logic     ref_clk,   // System sampling clock
  input  wire logic     reset,     // Synchronous, active high
  input  wire port_in_t pins,      // Raw test port pins
  output port_in_t      synced,    // Pins after two flops
  output logic          tck_rise,  // One-cycle pulse on test clock rise
  output logic          tck_fall   // One-cycle pulse on test clock fall
);

  port_in_t meta_r, meta_nxt;
  port_in_t sync_r, sync_nxt;
  logic     prev_r, prev_nxt;

  // Two flops before any logic reads a pin
  always_comb begin
    meta_nxt = reset ? port_in_t'(0) : pins;
    sync_nxt = reset ? port_in_t'(0) : meta_r;
    prev_nxt = reset ? 1'b0 : sync_r.tck;
  end

  always_ff @(posedge ref_clk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
    prev_r <= prev_nxt;
  end

  assign synced   = sync_r;
  assign tck_rise = sync_r.tck & ~prev_r;
  assign tck_fall = ~sync_r.tck & prev_r;

endmodule
`default_nettype wire

// ---- verilog/scan_tap.sv ----
// Purpose: Boundary-scan test access port with bypass, identity and pin chain.
// Assumes: Test clock slower than ref_clk / 4; test reset pin active high here.
// Notes: Pins pass straight through unless a driving or pads-off test instruction is live.
`timescale 1ns/1ns
`default_nettype none
module scan_tap
  import scan_pkg::*;
(
  input  wire logic               ref_clk,  // 10 MHz sampling clock
  input  wire logic               reset,    // Synchronous, active high
  input  wire logic               tck,      // Test clock pin
  input  wire logic               tms,      // Mode select pin
  input  wire logic               tdi,      // Serial data in pin
  input  wire logic               trst,     // Test reset pin, active high
  output logic                    tdo,      // Serial data out
  output logic                    tdo_oe,   // High while serial out drives
  input  wire pin_side_t          pin_side, // Core outputs, enables, pad levels
  output logic [PIN_CNT-1:0]      pad_out,  // Level toward each pad
  output logic [PIN_CNT-1:0]      pad_oe,   // Drive enable toward each pad
  output logic [PIN_CNT-1:0]      core_in   // Pad level handed to the core
);

  port_in_t   sp;
  logic       rise, fall;
  tap_state_t st_r, st_nxt;
  logic [IR_LEN-1:0]  ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
  logic [BSR_LEN-1:0] bsr_r, bsr_nxt, upd_r, upd_nxt;
  logic [IDR_LEN-1:0] id_r, id_nxt;
  logic               byp_r, byp_nxt;
  logic               tdo_r, tdo_nxt, oe_r, oe_nxt;
  logic               serial_bit;
  logic               drive_test, all_off;

  edge_sync u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .pins     ({tck, tms, tdi, trst}),
    .synced   (sp),
    .tck_rise (rise),
    .tck_fall (fall)
  );

  // State walk on each rising test clock
  always_comb begin
    st_nxt = st_r;
    if (sp.trst) begin
      st_nxt = ST_RESET;
    end else if (rise) begin
      case (st_r)
        ST_RESET:  st_nxt = sp.tms ? ST_RESET  : ST_IDLE;
        ST_IDLE:   st_nxt = sp.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: st_nxt = sp.tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: st_nxt = sp.tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  st_nxt = sp.tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: st_nxt = sp.tms ? ST_UPD_DR : ST_PA_DR;
        ST_PA_DR:  st_nxt = sp.tms ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: st_nxt = sp.tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: st_nxt = sp.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: st_nxt = sp.tms ? ST_RESET  : ST_CAP_IR;
        ST_CAP_IR: st_nxt = sp.tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  st_nxt = sp.tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: st_nxt = sp.tms ? ST_UPD_IR : ST_PA_IR;
        ST_PA_IR:  st_nxt = sp.tms ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: st_nxt = sp.tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: st_nxt = sp.tms ? ST_SEL_DR : ST_IDLE;
        default:   st_nxt = ST_RESET;
      endcase
    end
  end

  // Instruction shift and latch; reset state forces the identity code
  always_comb begin
    ir_sh_nxt = ir_sh_r;
    ir_nxt    = ir_r;
    if (st_r == ST_RESET) begin
      ir_nxt = INS_IDCODE;
    end
    if (rise) begin
      case (st_r)
        ST_CAP_IR: ir_sh_nxt = IR_CAPTURE;
        ST_SH_IR:  ir_sh_nxt = {sp.tdi, ir_sh_r[IR_LEN-1:1]};
        ST_UPD_IR: ir_nxt    = ir_sh_r;
        default:   ir_sh_nxt = ir_sh_r;
      endcase
    end
  end

  // Data registers: all capture together; shift and update per selected instruction
  always_comb begin
    bsr_nxt = bsr_r;
    upd_nxt = upd_r;
    id_nxt  = id_r;
    byp_nxt = byp_r;
    if (rise) begin
      case (st_r)
        ST_CAP_DR: begin
          // Even cells hold pad input, odd cells the core drive level
          for (int i = 0; i < PIN_CNT; i++) begin
            bsr_nxt[2*i]   = pin_side.pad_in[i];
            bsr_nxt[2*i+1] = pin_side.core_out[i];
          end
          id_nxt  = ID_VALUE;
          byp_nxt = 1'b0;
        end
        ST_SH_DR: begin
          case (ir_r)
            INS_EXTEST, INS_SAMPLE: bsr_nxt = {sp.tdi, bsr_r[BSR_LEN-1:1]};
            INS_IDCODE:             id_nxt  = {sp.tdi, id_r[IDR_LEN-1:1]};
            default:                byp_nxt = sp.tdi;
          endcase
        end
        ST_UPD_DR: begin
          // Update only from boundary instructions; sample doubles as preload
          if (ir_r == INS_EXTEST || ir_r == INS_SAMPLE) begin
            upd_nxt = bsr_r;
          end
        end
        default: byp_nxt = byp_r;
      endcase
    end
  end

  // Which register feeds serial out
  always_comb begin
    if (st_r == ST_SH_IR) begin
      serial_bit = ir_sh_r[0];
    end else begin
      case (ir_r)
        INS_EXTEST, INS_SAMPLE: serial_bit = bsr_r[0];
        INS_IDCODE:             serial_bit = id_r[0];
        default:                serial_bit = byp_r;
      endcase
    end
  end

  // Serial out moves on the falling test clock; test reset clears its enable at any time
  always_comb begin
    tdo_nxt = tdo_r;
    oe_nxt  = oe_r;
    if (sp.trst) begin
      oe_nxt = 1'b0;
    end else if (fall) begin
      tdo_nxt = serial_bit;
      oe_nxt  = (st_r == ST_SH_DR) || (st_r == ST_SH_IR);
    end
  end

  // Sequencer state lives on ref_clk alone and ignores core state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Instruction registers; identity code after any reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ir_sh_r <= IR_CAPTURE;
      ir_r    <= INS_IDCODE;
    end else begin
      ir_sh_r <= ir_sh_nxt;
      ir_r    <= ir_nxt;
    end
  end

  // Data registers and update latch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bsr_r <= '0;
      upd_r <= '0;
      id_r  <= ID_VALUE;
      byp_r <= 1'b0;
    end else begin
      bsr_r <= bsr_nxt;
      upd_r <= upd_nxt;
      id_r  <= id_nxt;
      byp_r <= byp_nxt;
    end
  end

  // Serial out; a fresh reset leaves the line undriven
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tdo_r <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      tdo_r <= tdo_nxt;
      oe_r  <= oe_nxt;
    end
  end

  // Pin muxing; sample and bypass leave the pins transparent
  assign drive_test = (ir_r == INS_EXTEST) || (ir_r == INS_CLAMP);
  assign all_off    = (ir_r == INS_HIGHZ);

  // Pads take test levels only from the update latch, so shifting never glitches them

  generate
    for (genvar g = 0; g < PIN_CNT; g++) begin : g_pin
      always_comb begin
        if (all_off) begin
          pad_out[g] = 1'b0;
          pad_oe[g]  = 1'b0;
        end else if (drive_test) begin
          pad_out[g] = upd_r[2*g+1];
          pad_oe[g]  = 1'b1;
        end else begin
          pad_out[g] = pin_side.core_out[g];
          pad_oe[g]  = pin_side.core_oe[g];
        end
      end
      assign core_in[g] = pin_side.pad_in[g];
    end
  endgenerate

  assign tdo    = tdo_r;
  assign tdo_oe = oe_r;

endmodule
`default_nettype wire

// ---- verification/scan_tap_chk.sv ----
// Purpose: Port-level checks of the boundary-scan test port.
// Assumes: Test clock phases of 3 ref_clk or longer.
// Notes: Bound to every scan_tap instance.
`timescale 1ns/1ns
`default_nettype none
module scan_tap_chk
  import scan_pkg::*;
(
  input wire logic               ref_clk,  // Clock
  input wire logic               reset,    // Sync reset
  input wire logic               tck,      // Test clock pin
  input wire logic               trst,     // Test reset pin
  input wire logic               tdo,      // Serial out
  input wire logic               tdo_oe,   // Serial out enable
  input wire pin_side_t          pin_side, // Core side of pins
  input wire logic [PIN_CNT-1:0] pad_out,  // Pad level
  input wire logic [PIN_CNT-1:0] pad_oe,   // Pad enable
  input wire logic [PIN_CNT-1:0] core_in   // Level to core
);
  default clocking cb @(posedge ref_clk); endclocking
  // Deep in the high phase any fall-launched change has long landed
  sequence tck_hi;
    tck [*3];
  endsequence
  // Long enough for the test reset to pass both sync stages
  sequence trst_on;
    trst [*6];
  endsequence
  sequence rst_on;
    reset [*2];
  endsequence
  AST_TDO_STEADY: assert property (disable iff (reset) tck_hi |-> $stable(tdo))
    else $error("tdo moved while tck high");
  AST_OE_STEADY: assert property (disable iff (reset) tck_hi |-> $stable(tdo_oe))
    else $error("tdo_oe moved while tck high");
  AST_RST_QUIET: assert property (reset |=> !tdo && !tdo_oe)
    else $error("serial out active in reset");
  AST_REL_QUIET: assert property ($fell(reset) |-> (!tdo_oe) [*8])
    else $error("shift state right after reset");
  AST_TRST_QUIET: assert property (disable iff (reset) trst_on |-> !tdo_oe)
    else $error("serial out active in test reset");
  AST_TRST_PADS: assert property (disable iff (reset) trst_on |-> pad_oe == pin_side.core_oe)
    else $error("pads not core driven after test reset");
  AST_RST_PADS: assert property (rst_on |-> pad_out == pin_side.core_out && pad_oe == pin_side.core_oe)
    else $error("pads not core driven in reset");
  AST_CORE_IN: assert property (core_in == pin_side.pad_in)
    else $error("core input not transparent");
endmodule
bind scan_tap scan_tap_chk i_chk (.ref_clk(ref_clk), .reset(reset), .tck(tck), .trst(trst),
  .tdo(tdo), .tdo_oe(tdo_oe), .pin_side(pin_side), .pad_out(pad_out), .pad_oe(pad_oe),
  .core_in(core_in));
`default_nettype wire

// ---- verification/jtag_host.sv ----
// Purpose: Board test controller model driving the test port pins.
// Assumes: Bit period 8 ref_clk (800 ns); pins move at ref_clk fall.
// Notes: Test clock rests low between frames.
`timescale 1ns/1ns
`default_nettype none
module jtag_host
  import scan_pkg::*;
(
  input  wire logic ref_clk, // Sampling clock
  input  wire logic tdo,     // Device serial out
  output logic      tck,     // Test clock
  output logic      tms,     // Mode select
  output logic      tdi,     // Serial data
  output logic      trst     // Test reset, active high
);
  logic [263:0] din;
  logic [263:0] dout;
  initial {tck, tms, tdi, trst} = 4'b0100;
  // One bit; data set well before the rise, out sampled just before the fall
  task automatic step(input logic m, input logic d, output logic q);
    @(negedge ref_clk);
    {tms, tdi} = {m, d};
    repeat (4) @(negedge ref_clk);
    tck = 1'b1;
    repeat (3) @(negedge ref_clk);
    q = tdo;
    tck = 1'b0;
  endtask
  // Mode bits, first one in bit 0
  task automatic walk(input logic [7:0] ms, input int n);
    logic q;
    for (int k = 0; k < n; k++) step(ms[k], 1'b0, q);
  endtask
  // Idle to shift, n bits through, update, back to idle
  task automatic scan(input logic ir, input int n);
    logic q;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], q);
      dout[k] = q;
    end
    walk(8'h01, 2);
  endtask
  task automatic pulse_trst();
    @(negedge ref_clk);
    trst = 1'b1;
    repeat (8) @(negedge ref_clk);
    trst = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for the boundary-scan test port.
// Assumes: Controller model paces the test clock at 800 ns.
// Notes: Row table covers each instruction; resets are hand-written.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); \
  end \
end
module tb
  import scan_pkg::*;
;
  typedef struct packed {
    logic [IR_LEN-1:0] ins;
    logic [8:0]        len;
    logic [1:0]        mode; // 0 core, 1 drive, 2 off
  } row_t;
  row_t rows [7] = '{'{INS_BYPASS, 9'd1, 2'd0}, '{INS_IDCODE, 9'd32, 2'd0},
    '{INS_SAMPLE, 9'd256, 2'd0}, '{INS_EXTEST, 9'd256, 2'd1}, '{INS_CLAMP, 9'd1, 2'd1},
    '{INS_HIGHZ, 9'd1, 2'd2}, '{4'h5, 9'd1, 2'd0}};
  logic               ref_clk = 1'b0;
  logic               reset = 1'b1;
  logic               tck, tms, tdi, trst, tdo, tdo_oe;
  pin_side_t          pin_side = {{16{8'h5c}}, {8{16'h00ff}}, {4{32'h1357_9bdf}}};
  logic [PIN_CNT-1:0] pad_out, pad_oe, core_in, drv, cap;
  logic [263:0]       pat = {33{8'h96}};
  int                 err_count = 0;
  int                 total_checks = 0;

  always #50 ref_clk = ~ref_clk;
  jtag_host i_host (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .trst(trst));
  scan_tap i_dut (.ref_clk(ref_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
    .trst(trst), .tdo(tdo), .tdo_oe(tdo_oe), .pin_side(pin_side), .pad_out(pad_out),
    .pad_oe(pad_oe), .core_in(core_in));

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Instruction load; the capture pattern comes back on the way
  task automatic load(input logic [IR_LEN-1:0] ins);
    i_host.din[IR_LEN-1:0] = ins;
    i_host.scan(1'b1, IR_LEN);
    `CHK("ir_cap", IR_CAPTURE, i_host.dout[IR_LEN-1:0])
  endtask
  // After any reset the identity register must be selected
  task automatic id_check();
    i_host.scan(1'b0, IDR_LEN);
    `CHK("idcode", ID_VALUE, i_host.dout[IDR_LEN-1:0])
  endtask
  // Hang guard; a run this long means a stuck sequence
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end
  // Preloaded output cells land on odd chain positions, eight bits past the pattern start
  initial begin
    for (int i = 0; i < PIN_CNT; i++) drv[i] = pat[2*i+9];
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    i_host.walk(8'h1f, 6);
    id_check();
    foreach (rows[r]) begin
      load(rows[r].ins);
      i_host.din = pat;
      i_host.scan(1'b0, rows[r].len + 8);
      `CHK("path", 8'h96, i_host.dout[rows[r].len +: 8])
      if (rows[r].len == IDR_LEN) `CHK("id", ID_VALUE, i_host.dout[31:0])
      for (int i = 0; i < PIN_CNT; i++) cap[i] = i_host.dout[2*i];
      if (rows[r].len == BSR_LEN) `CHK("cap", pin_side.pad_in, cap)
      @(negedge ref_clk);
      case (rows[r].mode)
        2'd0: `CHK("pads", {pin_side.core_oe, pin_side.core_out}, {pad_oe, pad_out})
        2'd1: `CHK("pads", {{PIN_CNT{1'b1}}, drv}, {pad_oe, pad_out})
        default: `CHK("pad_oe", {PIN_CNT{1'b0}}, pad_oe)
      endcase
    end
    // Test reset pin from a shift state under the pads-off instruction
    load(INS_HIGHZ);
    i_host.walk(8'h01, 3);
    repeat (3) @(negedge ref_clk);
    `CHK("oe_shift", 1'b1, tdo_oe)
    i_host.pulse_trst();
    `CHK("oe_trst", 1'b0, tdo_oe)
    `CHK("pads_trst", pin_side.core_oe, pad_oe)
    i_host.walk(8'h00, 1);
    id_check();
    // Five mode-high clocks from inside a shift state
    load(INS_BYPASS);
    i_host.walk(8'h01, 3);
    i_host.walk(8'h1f, 6);
    id_check();
    // System reset while pads are released
    load(INS_HIGHZ);
    reset = 1'b1;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    `CHK("pads_rst", pin_side.core_oe, pad_oe)
    `CHK("core_in", pin_side.pad_in, core_in)
    i_host.walk(8'h00, 1);
    id_check();
    end_sim();
  end
endmodule
`default_nettype wire
